// ===== verilog/mtd_params.svh
// Constants for the memory-op trap decision block
`ifndef MTD_PARAMS_SVH
`define MTD_PARAMS_SVH

// ==================================================
// Clock and cycle counter
`define MTD_CLK_HZ 25000000
`define MTD_CNT_YEARS 10
`define MTD_SEC_PER_YEAR 31536000
`define MTD_CNT_ARCH_W 63

// ==================================================
// Selector ranges, all eight bits compared
`define MTD_ASI_W 8
`define MTD_ASI_HYPER_LO 8'h30
`define MTD_ASI_UNRESTR_LO 8'h80

// ==================================================
// Prefetch geometry and variants
`define MTD_PF_FCN_W 5
`define MTD_PF_MIN_BLOCK 64
`define MTD_PF_IMPL_SPEC_MASK 32'hff0d_0000

// ==================================================
// Instruction fields
`define MTD_ADDR_W 64
`define MTD_INSTR_12_5_W 8
`define MTD_INSTR_12_5_ZERO 8'h00

// ==================================================
// Trap type codes
`define MTD_TT_W 9
`define MTD_TT_NONE 9'h000
`define MTD_TT_ILLEGAL 9'h010
`define MTD_TT_PRIV_ACTION 9'h037
`define MTD_TT_BAD_ASI 9'h030
`define MTD_TT_MEM_MISALIGN 9'h034
`define MTD_TT_DLD_MISALIGN 9'h035
`define MTD_TT_DST_MISALIGN 9'h036
`define MTD_TT_TWIN_LD 9'h076
`define MTD_TT_TWIN_ST 9'h077
`define MTD_TT_WIN_SCRUB 9'h024
`define MTD_TT_STD_LO 9'h060
`define MTD_TT_STD_HI 9'h07f
`define MTD_TT_PRIVATE_DFLT 9'h0c0

// ==================================================
// Trap depth limits
`define MTD_TL_W 3
`define MTD_TL_MIN 2
`define MTD_TL_MAX 6

`endif

// ===== verilog/mtd_pkg.sv
// Types shared by the memory-op trap decision block
package mtd_pkg;
`include "mtd_params.svh"

    // ==================================================
    // Operation classes issued by the pipeline
    typedef enum logic [3:0] {
        MTD_OP_NONE = 4'h0,
        MTD_OP_PREFETCH = 4'h1,
        MTD_OP_TWIN_LD = 4'h2,
        MTD_OP_TWIN_ST = 4'h3,
        MTD_OP_DFP_LD = 4'h4,
        MTD_OP_DFP_ST = 4'h5,
        MTD_OP_ISYNC = 4'h6,
        MTD_OP_WIN_CLEAN = 4'h7,
        MTD_OP_IMPL_TRAP = 4'h8
    } mtd_op_e;

    // Selector privilege classes
    typedef enum logic [1:0] {
        MTD_ASI_RESTR_PRIV = 2'h0,
        MTD_ASI_RESTR_HYPER = 2'h1,
        MTD_ASI_UNRESTR = 2'h2
    } mtd_asi_cls_e;

    // Prefetch handling modes
    typedef enum logic [1:0] {
        MTD_PF_NOP = 2'h0,
        MTD_PF_FULL = 2'h1,
        MTD_PF_COMMON = 2'h2
    } mtd_pf_mode_e;

    // ==================================================
    // Request from the pipeline
    typedef struct packed {
        mtd_op_e op;
        logic alt;
        logic [`MTD_ASI_W-1:0] asi;
        logic imm;
        logic [`MTD_INSTR_12_5_W-1:0] instr_12_5;
        logic [`MTD_ADDR_W-1:0] addr;
        logic priv;
        logic [`MTD_PF_FCN_W-1:0] pf_fcn;
        logic [`MTD_TT_W-1:0] impl_tt;
    } mtd_req_s;

    // Decision back to the pipeline
    typedef struct packed {
        logic trap;
        logic [`MTD_TT_W-1:0] tt;
        logic nop;
        logic issue;
        logic hw_clean;
        mtd_pf_mode_e pf_mode;
        logic [`MTD_ADDR_W-1:0] pf_addr;
    } mtd_rsp_s;
endpackage : mtd_pkg

// ===== verilog/mtd_asi_decode.sv
// Full eight-bit address space selector decoder
`timescale 1ns/1ps
`include "mtd_params.svh"
module mtd_asi_decode #(
    parameter logic [255:0] IMPL_MASK = {256{1'b1}}
) (
    input wire logic [`MTD_ASI_W-1:0] i_asi,
    output mtd_pkg::mtd_asi_cls_e o_cls,
    output logic o_impl
);
    import mtd_pkg::*;

    // ==================================================
    // Class from the selector value
    function automatic mtd_asi_cls_e asi_class(input logic [`MTD_ASI_W-1:0] a);
        if (a >= `MTD_ASI_UNRESTR_LO) begin
            return MTD_ASI_UNRESTR;
        end else if (a >= `MTD_ASI_HYPER_LO) begin
            return MTD_ASI_RESTR_HYPER;
        end else begin
            return MTD_ASI_RESTR_PRIV;
        end
    endfunction : asi_class

    // No bit is dropped: the mask is indexed by the whole value
    always_comb begin
        o_cls = asi_class(i_asi);
        o_impl = IMPL_MASK[i_asi];
    end
endmodule : mtd_asi_decode

// ===== verilog/mtd_cycle_counter.sv
// Free-running cycle counter with zero-reading upper bits
`timescale 1ns/1ps
`include "mtd_params.svh"
module mtd_cycle_counter #(
    parameter int CNT_W = `MTD_CNT_ARCH_W
) (
    input wire logic i_clk,
    input wire logic i_rst_n,
    output logic [`MTD_CNT_ARCH_W-1:0] o_count
);
    import mtd_pkg::*;

    // ==================================================
    // Width needed for ten years at the core rate
    localparam longint unsigned TEN_YEAR_CYCLES =
        64'(`MTD_CNT_YEARS) * 64'(`MTD_SEC_PER_YEAR) * 64'(`MTD_CLK_HZ);
    localparam int MIN_W = $clog2(TEN_YEAR_CYCLES);
    // Narrow settings are widened so overflow stays beyond ten years
    localparam int EFF_W = (CNT_W < MIN_W) ? MIN_W : ((CNT_W > `MTD_CNT_ARCH_W) ? `MTD_CNT_ARCH_W : CNT_W);

    logic [EFF_W-1:0] cnt_r;
    logic [EFF_W-1:0] cnt_nxt;

    // Next count
    always_comb begin
        cnt_nxt = cnt_r + EFF_W'(1);
    end

    // Count register
    always_ff @(posedge i_clk) begin
        if (!i_rst_n) begin
            cnt_r <= '0;
        end else begin
            cnt_r <= cnt_nxt;
        end
    end

    // Unimplemented upper bits read as zero
    always_comb begin
        o_count = '0;
        o_count[EFF_W-1:0] = cnt_r;
    end
endmodule : mtd_cycle_counter

// ===== verilog/mtd_trap_decide.sv
// Trap decision for memory-access instructions
`timescale 1ns/1ps
`include "mtd_params.svh"
module mtd_trap_decide #(
    parameter bit TWIN_LD_HW = 1'b0,
    parameter bit TWIN_ST_HW = 1'b0,
    parameter bit HW_WIN_CLEAN = 1'b0,
    parameter int MAX_TL = `MTD_TL_MIN,
    parameter int PF_BLOCK = `MTD_PF_MIN_BLOCK,
    parameter logic [31:0] PF_DEFINED = 32'h00f0_001f,
    parameter logic [31:0] PF_IMPL = 32'h0000_0000,
    parameter logic [63:0] PF_MODES = {32{2'b10}},
    parameter logic [255:0] ASI_IMPL = {256{1'b1}},
    parameter int CNT_W = `MTD_CNT_ARCH_W
) (
    input wire logic I_CLOCK,
    input wire logic I_RST_N,
    input wire logic I_REQ_VALID,
    input wire mtd_pkg::mtd_req_s I_REQ,
    output logic O_REQ_READY,
    output logic O_RSP_VALID,
    output mtd_pkg::mtd_rsp_s O_RSP,
    input wire logic I_TRAP_ACK,
    input wire logic I_TRAP_RETURN,
    output logic [`MTD_TL_W-1:0] O_TRAP_LEVEL,
    output logic O_TL_AT_MAX,
    output logic [`MTD_CNT_ARCH_W-1:0] O_CYCLE_COUNT
);
    import mtd_pkg::*;

    // ==================================================
    // Elaboration-time limits
    // The depth limit is forced into the legal band so a bad setting cannot escape it
    localparam int EFF_TL = (MAX_TL < `MTD_TL_MIN) ? `MTD_TL_MIN :
        ((MAX_TL > `MTD_TL_MAX) ? `MTD_TL_MAX : MAX_TL);
    localparam logic [`MTD_TL_W-1:0] TL_LIMIT = `MTD_TL_W'(EFF_TL);
    // A block size below the minimum is raised to it; one that is not a power of two
    // rounds up, so the hint never covers less than was asked for
    localparam int BLK = (PF_BLOCK < `MTD_PF_MIN_BLOCK) ? `MTD_PF_MIN_BLOCK : PF_BLOCK;
    localparam int BLK_LG = $clog2(BLK);

    // ==================================================
    // States
    // One-hot codes, one bit per state
    typedef enum logic [1:0] {
        ST_READY = 2'b01,
        ST_TRAP_WAIT = 2'b10
    } mtd_state_e;

    // Registered state, answer and depth
    mtd_state_e state_r;
    mtd_state_e state_nxt;
    logic rsp_valid_r;
    logic rsp_valid_nxt;
    mtd_rsp_s rsp_r;
    mtd_rsp_s rsp_nxt;
    logic [`MTD_TL_W-1:0] tl_r;
    logic [`MTD_TL_W-1:0] tl_nxt;

    // Decoder results and the combinational decision
    mtd_asi_cls_e asi_cls;
    logic asi_impl;
    logic accept;
    mtd_rsp_s decide;

    // ==================================================
    // Selector decoder and cycle counter
    // The counter runs on its own; nothing in the decision reads it
    mtd_asi_decode #(
        .IMPL_MASK(ASI_IMPL)
    ) u_asi_decode (
        .i_asi(I_REQ.asi),
        .o_cls(asi_cls),
        .o_impl(asi_impl)
    );

    mtd_cycle_counter #(
        .CNT_W(CNT_W)
    ) u_cycle_counter (
        .i_clk(I_CLOCK),
        .i_rst_n(I_RST_N),
        .o_count(O_CYCLE_COUNT)
    );

    // ==================================================
    // Helpers
    // Private codes landing in the standard band are moved out of it
    function automatic logic [`MTD_TT_W-1:0] private_tt(input logic [`MTD_TT_W-1:0] tt);
        if (tt >= `MTD_TT_STD_LO && tt <= `MTD_TT_STD_HI) begin
            return `MTD_TT_PRIVATE_DFLT;
        end else begin
            return tt;
        end
    endfunction : private_tt

    // Twin-word forms, plain or alternate
    function automatic logic is_twin(input mtd_op_e op);
        return (op == MTD_OP_TWIN_LD) || (op == MTD_OP_TWIN_ST);
    endfunction : is_twin

    // Double floating-point forms, plain or alternate
    function automatic logic is_double(input mtd_op_e op);
        return (op == MTD_OP_DFP_LD) || (op == MTD_OP_DFP_ST);
    endfunction : is_double

    // Handling of one prefetch variant
    // The table is fixed per build, so a variant is handled the same way every time
    function automatic mtd_pf_mode_e pf_variant(input logic [`MTD_PF_FCN_W-1:0] fcn);
        logic [1:0] m;
        logic [31:0] spec;
        m = PF_MODES[2*fcn +: 2];
        spec = `MTD_PF_IMPL_SPEC_MASK;
        if (spec[fcn]) begin
            // Implementation-specific slot: nop unless built
            return PF_IMPL[fcn] ? mtd_pf_mode_e'(m) : MTD_PF_NOP;
        end else if (m == MTD_PF_FULL || m == MTD_PF_COMMON) begin
            return mtd_pf_mode_e'(m);
        end else begin
            return MTD_PF_NOP;
        end
    endfunction : pf_variant

    // ==================================================
    // Decision for the request on the inputs
    // Candidate traps are tested in one fixed order, highest first
    always_comb begin
        logic dfp_valid;
        logic word_bad;
        logic odd_word;
        logic asi_blocked;
        logic is_mem;
        // A double form is valid with an immediate offset or with bits 12:5 clear
        dfp_valid = I_REQ.imm || (I_REQ.instr_12_5 == `MTD_INSTR_12_5_ZERO);
        // Alignment is judged from the address alone, before anything goes to memory
        word_bad = (I_REQ.addr[1:0] != 2'b00);
        odd_word = !word_bad && I_REQ.addr[2];
        // Unprivileged code reaches only the unrestricted range; privileged code not the hyper band
        asi_blocked = I_REQ.alt && ((!I_REQ.priv && asi_cls != MTD_ASI_UNRESTR) ||
            (I_REQ.priv && asi_cls == MTD_ASI_RESTR_HYPER));
        is_mem = is_twin(I_REQ.op) || is_double(I_REQ.op);
        decide = '0;
        decide.tt = `MTD_TT_NONE;
        decide.pf_mode = MTD_PF_NOP;
        decide.issue = 1'b1;
        case (I_REQ.op)
            MTD_OP_PREFETCH: begin
                decide.issue = 1'b0;
                // Never traps; blocked selectors and unimplemented ones fall to nop
                if (I_REQ.alt && (asi_blocked || !asi_impl)) begin
                    decide.nop = 1'b1;
                end else if (!PF_DEFINED[I_REQ.pf_fcn] && !PF_IMPL[I_REQ.pf_fcn]) begin
                    decide.nop = 1'b1;
                end else begin
                    decide.pf_mode = pf_variant(I_REQ.pf_fcn);
                    decide.nop = (decide.pf_mode == MTD_PF_NOP);
                    decide.issue = !decide.nop;
                end
                // Hint only: no trap, no register write, block aligned
                decide.pf_addr = {I_REQ.addr[`MTD_ADDR_W-1:BLK_LG], {BLK_LG{1'b0}}};
            end
            MTD_OP_ISYNC: begin
                // Always done in hardware; there is no emulation path for it
                decide.issue = 1'b1;
            end
            MTD_OP_WIN_CLEAN: begin
                if (HW_WIN_CLEAN) begin
                    decide.hw_clean = 1'b1;
                end else begin
                    // Trapping: nothing goes on to execute
                    decide.trap = 1'b1;
                    decide.issue = 1'b0;
                    decide.tt = `MTD_TT_WIN_SCRUB;
                end
            end
            MTD_OP_IMPL_TRAP: begin
                decide.trap = 1'b1;
                decide.tt = private_tt(I_REQ.impl_tt);
                decide.issue = 1'b0;
            end
            default: begin
                // Loads and stores go on unless the chain below traps
                decide.issue = is_mem;
            end
        endcase
        if (is_mem) begin
            // Fixed order: illegal, selector privilege, bad selector, missing op, alignment
            // Twin forms need doubleword alignment too, with no misalignment trap of their own
            if (is_double(I_REQ.op) && !dfp_valid) begin
                decide.tt = `MTD_TT_ILLEGAL;
            end else if (asi_blocked) begin
                decide.tt = `MTD_TT_PRIV_ACTION;
            end else if (I_REQ.alt && !asi_impl) begin
                decide.tt = `MTD_TT_BAD_ASI;
            end else if (I_REQ.op == MTD_OP_TWIN_LD && !TWIN_LD_HW) begin
                decide.tt = `MTD_TT_TWIN_LD;
            end else if (I_REQ.op == MTD_OP_TWIN_ST && !TWIN_ST_HW) begin
                decide.tt = `MTD_TT_TWIN_ST;
            end else if (word_bad || (odd_word && is_twin(I_REQ.op))) begin
                decide.tt = `MTD_TT_MEM_MISALIGN;
            end else if (odd_word && I_REQ.op == MTD_OP_DFP_LD) begin
                decide.tt = `MTD_TT_DLD_MISALIGN;
            end else if (odd_word && I_REQ.op == MTD_OP_DFP_ST) begin
                decide.tt = `MTD_TT_DST_MISALIGN;
            end
            decide.trap = (decide.tt != `MTD_TT_NONE);
            // A trapping access is never sent to memory
            decide.issue = !decide.trap;
        end
    end

    // ==================================================
    // Sequencing: one decision at a time, stall until the trap is taken
    // Holding younger requests back while a trap waits keeps every trap precise
    assign accept = I_REQ_VALID && (state_r == ST_READY);

    // Next state and answer; the answer keeps its value between pulses
    always_comb begin
        state_nxt = state_r;
        rsp_valid_nxt = accept;
        rsp_nxt = rsp_r;
        if (accept) begin
            rsp_nxt = decide;
        end
        case (state_r)
            ST_READY: begin
                // Nothing younger is accepted once a trap is decided
                if (accept && decide.trap) begin
                    state_nxt = ST_TRAP_WAIT;
                end
            end
            ST_TRAP_WAIT: begin
                if (I_TRAP_ACK) begin
                    state_nxt = ST_READY;
                end
            end
            default: begin
                state_nxt = ST_READY;
            end
        endcase
    end

    // Registers only; the synchronous reset clears the answer as well
    always_ff @(posedge I_CLOCK) begin
        if (!I_RST_N) begin
            state_r <= ST_READY;
            rsp_valid_r <= 1'b0;
            rsp_r <= '0;
        end else begin
            state_r <= state_nxt;
            rsp_valid_r <= rsp_valid_nxt;
            rsp_r <= rsp_nxt;
        end
    end

    // ==================================================
    // Trap depth: entry on acknowledge, exit on return
    // Saturates at the limit; the flag tells software nesting is exhausted
    // An acknowledge at the limit is dropped, but a return in that cycle still counts
    always_comb begin
        logic up;
        logic down;
        up = (state_r == ST_TRAP_WAIT) && I_TRAP_ACK && (tl_r < TL_LIMIT);
        down = I_TRAP_RETURN && (tl_r != '0);
        tl_nxt = tl_r;
        if (up && !down) begin
            tl_nxt = tl_r + `MTD_TL_W'(1);
        end else if (down && !up) begin
            tl_nxt = tl_r - `MTD_TL_W'(1);
        end
    end

    // Depth register
    always_ff @(posedge I_CLOCK) begin
        if (!I_RST_N) begin
            tl_r <= '0;
        end else begin
            tl_r <= tl_nxt;
        end
    end

    // ==================================================
    // Outputs
    // Ready follows the state directly; answer and depth come from flip-flops
    assign O_REQ_READY = (state_r == ST_READY);
    assign O_RSP_VALID = rsp_valid_r;
    assign O_RSP = rsp_r;
    assign O_TRAP_LEVEL = tl_r;
    assign O_TL_AT_MAX = (tl_r == TL_LIMIT);
endmodule : mtd_trap_decide

// ===== verif/mtd_trap_decide_props.sv
// Checker for the memory-op trap decision block
`timescale 1ns/1ps
`include "mtd_params.svh"
module mtd_trap_decide_props import mtd_pkg::*; #(
    parameter int MAX_TL = 2
) (
    input wire logic I_CLOCK,
    input wire logic I_RST_N,
    input wire logic I_REQ_VALID,
    input wire mtd_pkg::mtd_req_s I_REQ,
    input wire logic O_REQ_READY,
    input wire logic O_RSP_VALID,
    input wire mtd_pkg::mtd_rsp_s O_RSP,
    input wire logic I_TRAP_ACK,
    input wire logic I_TRAP_RETURN,
    input wire logic [`MTD_TL_W-1:0] O_TRAP_LEVEL,
    input wire logic O_TL_AT_MAX,
    input wire logic [`MTD_CNT_ARCH_W-1:0] O_CYCLE_COUNT
);
    logic acc;

    // ==================================================
    // Properties, all on the core clock
    assign acc = I_REQ_VALID && O_REQ_READY;
    default clocking cb @(posedge I_CLOCK); endclocking
    default disable iff (!I_RST_N);

    take_answer_a: assert property (acc |=> O_RSP_VALID)
        else $error("answer missing after take");
    trap_refuse_a: assert property (O_RSP_VALID && O_RSP.trap |-> !O_REQ_READY)
        else $error("request taken while trap pending");
    dld_odd_a: assert property (acc && I_REQ.op == MTD_OP_DFP_LD && I_REQ.addr[2:0] == 3'h4
        && (!I_REQ.alt || I_REQ.asi >= `MTD_ASI_UNRESTR_LO) && (I_REQ.imm || I_REQ.instr_12_5 == 8'h00)
        |=> O_RSP.trap && O_RSP.tt == `MTD_TT_DLD_MISALIGN)
        else $error("double load misalign missed");
    dst_odd_a: assert property (acc && I_REQ.op == MTD_OP_DFP_ST && I_REQ.addr[2:0] == 3'h4
        && (!I_REQ.alt || I_REQ.asi >= `MTD_ASI_UNRESTR_LO) && (I_REQ.imm || I_REQ.instr_12_5 == 8'h00)
        |=> O_RSP.trap && O_RSP.tt == `MTD_TT_DST_MISALIGN)
        else $error("double store misalign missed");
    twin_miss_a: assert property (acc && (I_REQ.op == MTD_OP_TWIN_LD || I_REQ.op == MTD_OP_TWIN_ST)
        && (!I_REQ.alt || I_REQ.asi >= `MTD_ASI_UNRESTR_LO)
        |=> O_RSP.trap && O_RSP.tt == ($past(I_REQ.op) == MTD_OP_TWIN_LD ? `MTD_TT_TWIN_LD : `MTD_TT_TWIN_ST))
        else $error("twin trap code wrong");
    isync_hw_a: assert property (acc && I_REQ.op == MTD_OP_ISYNC |=> !O_RSP.trap && O_RSP.issue)
        else $error("sync trapped");
    pf_quiet_a: assert property (acc && I_REQ.op == MTD_OP_PREFETCH
        |=> !O_RSP.trap && O_RSP.pf_addr[5:0] == 6'h00)
        else $error("prefetch trapped or unaligned");
    pf_block_nop_a: assert property (acc && I_REQ.op == MTD_OP_PREFETCH && I_REQ.alt
        && I_REQ.asi < `MTD_ASI_UNRESTR_LO && (!I_REQ.priv || I_REQ.asi >= `MTD_ASI_HYPER_LO)
        |=> O_RSP.nop && !O_RSP.issue && !O_RSP.trap)
        else $error("blocked prefetch not a nop");
    scrub_trap_a: assert property (acc && I_REQ.op == MTD_OP_WIN_CLEAN
        |=> O_RSP.trap && O_RSP.tt == `MTD_TT_WIN_SCRUB)
        else $error("window scrub missing");
    impl_code_a: assert property (acc && I_REQ.op == MTD_OP_IMPL_TRAP
        |=> O_RSP.trap && !(O_RSP.tt inside {[`MTD_TT_STD_LO:`MTD_TT_STD_HI]}))
        else $error("private trap in standard range");
    tl_bound_a: assert property (O_TRAP_LEVEL <= MAX_TL && O_TL_AT_MAX == (O_TRAP_LEVEL == MAX_TL))
        else $error("trap depth beyond limit");
    tl_cause_a: assert property (O_TRAP_LEVEL != $past(O_TRAP_LEVEL)
        |-> $past(I_TRAP_ACK || I_TRAP_RETURN))
        else $error("trap depth moved alone");
    count_step_a: assert property (I_RST_N |=> O_CYCLE_COUNT == $past(O_CYCLE_COUNT) + 1'b1)
        else $error("cycle count skipped");
endmodule : mtd_trap_decide_props

bind mtd_trap_decide mtd_trap_decide_props #(.MAX_TL(MAX_TL)) u_props (
    .I_CLOCK(I_CLOCK), .I_RST_N(I_RST_N), .I_REQ_VALID(I_REQ_VALID), .I_REQ(I_REQ),
    .O_REQ_READY(O_REQ_READY), .O_RSP_VALID(O_RSP_VALID), .O_RSP(O_RSP), .I_TRAP_ACK(I_TRAP_ACK),
    .I_TRAP_RETURN(I_TRAP_RETURN), .O_TRAP_LEVEL(O_TRAP_LEVEL), .O_TL_AT_MAX(O_TL_AT_MAX),
    .O_CYCLE_COUNT(O_CYCLE_COUNT)
);

// ===== verif/mtd_pipe_model.sv
// Pipeline-side model that issues requests and acknowledges traps
`timescale 1ns/1ps
module mtd_pipe_model import mtd_pkg::*; (
    input wire logic i_clk,
    input wire logic i_ready,
    input wire logic i_rsp_valid,
    input wire mtd_pkg::mtd_rsp_s i_rsp,
    output logic o_valid,
    output mtd_pkg::mtd_req_s o_req,
    output logic o_ack,
    output logic o_ret
);
    // ==================================================
    // Idle levels from time zero
    initial begin
        o_valid = 1'b0;
        o_req = '0;
        o_ack = 1'b0;
        o_ret = 1'b0;
    end

    // Request held until taken; ready read at the falling edge, where it has settled
    task automatic issue(input mtd_req_s req, input int ack_wait, output mtd_rsp_s rsp, output bit ok);
        int n;
        ok = 1'b0;
        @(negedge i_clk);
        o_valid = 1'b1;
        o_req = req;
        for (n = 0; n < 20 && !ok; n++) begin
            ok = i_ready;
            @(posedge i_clk);
            if (!ok) @(negedge i_clk);
        end
        @(negedge i_clk);
        o_valid = 1'b0;
        o_req = ~req; // Released fields must not keep the old value
        ok = ok && i_rsp_valid;
        rsp = i_rsp;
        if (rsp.trap) begin
            // Handler takes the trap, promptly or late
            repeat (ack_wait) @(negedge i_clk);
            o_ack = 1'b1;
            @(negedge i_clk);
            o_ack = 1'b0;
        end
    endtask : issue

    // One-cycle handler return
    task automatic ret();
        @(negedge i_clk);
        o_ret = 1'b1;
        @(negedge i_clk);
        o_ret = 1'b0;
    endtask : ret
endmodule : mtd_pipe_model

// ===== verif/memory_op_trap_decision_tb.sv
// Self-checking bench for the memory-op trap decision block
`timescale 1ns/1ps
`include "mtd_params.svh"
module memory_op_trap_decision_tb;
    import mtd_pkg::*;
    localparam int TL_LIM = 3;
    localparam logic [31:0] PF_DEF = 32'h00f0_001f;
    logic clk = 1'b0;
    logic rst_n = 1'b0;
    logic req_valid, ready, rsp_valid, ack, ret, at_max;
    mtd_req_s req;
    mtd_rsp_s rsp;
    logic [`MTD_TL_W-1:0] level;
    logic [`MTD_CNT_ARCH_W-1:0] count;
    int fail_count = 0;
    int total_checks = 0;
    int exp_tl = 0;
    int slow = 0;

    // ==================================================
    // Clock, design and pipeline model
    always #20 clk = ~clk;

    mtd_trap_decide #(.MAX_TL(TL_LIM), .PF_DEFINED(PF_DEF), .CNT_W(53)) dut (
        .I_CLOCK(clk), .I_RST_N(rst_n), .I_REQ_VALID(req_valid), .I_REQ(req), .O_REQ_READY(ready),
        .O_RSP_VALID(rsp_valid), .O_RSP(rsp), .I_TRAP_ACK(ack), .I_TRAP_RETURN(ret),
        .O_TRAP_LEVEL(level), .O_TL_AT_MAX(at_max), .O_CYCLE_COUNT(count));

    mtd_pipe_model u_pipe (.i_clk(clk), .i_ready(ready), .i_rsp_valid(rsp_valid), .i_rsp(rsp),
        .o_valid(req_valid), .o_req(req), .o_ack(ack), .o_ret(ret));

    task automatic check(input string name, input logic [63:0] seen, input logic [63:0] exp);
        total_checks++;
        if (seen !== exp) begin
            fail_count++;
            $display("[FAIL] %s expected %h seen %h", name, exp, seen);
        end
    endtask : check

    task automatic end_sim();
        $display("checks %0d mismatches %0d", total_checks, fail_count);
        if (fail_count == 0 && total_checks > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask : end_sim

    // One request; code is both prefetch variant and private trap code; tt zero means no trap
    task automatic send(input mtd_op_e op, input logic alt, input logic [7:0] asi, input logic imm,
        input logic [7:0] b, input logic [63:0] a, input logic pv, input logic [8:0] code,
        input logic [8:0] tt, input logic nop);
        mtd_req_s r;
        mtd_rsp_s s;
        bit ok;
        r = '{op, alt, asi, imm, b, a, pv, code[4:0], code};
        slow = 3 - slow; // Alternate prompt and late acknowledge
        u_pipe.issue(r, slow, s, ok);
        if (!ok) begin
            fail_count++;
            end_sim();
        end
        check("trap", s.trap, tt != 9'h000);
        if (tt != 9'h000) check("code", s.tt, tt);
        if (op == MTD_OP_PREFETCH) check("nop", s.nop, nop);
        else check("issue", s.issue, tt == 9'h000);
        if (tt != 9'h000 && exp_tl < TL_LIM) exp_tl++;
    endtask : send

    task automatic t_reset();
        check("ready", ready, 1'b1);
        check("rsp_valid", rsp_valid, 1'b0);
        check("level", level, 0);
    endtask : t_reset

    task automatic t_double();
        send(MTD_OP_DFP_LD, 0, 8'h00, 1, 8'h00, 64'h1004, 0, 0, `MTD_TT_DLD_MISALIGN, 0);
        send(MTD_OP_DFP_ST, 1, 8'h80, 0, 8'h00, 64'h200c, 0, 0, `MTD_TT_DST_MISALIGN, 0);
        send(MTD_OP_DFP_LD, 0, 8'h00, 0, 8'h00, 64'h2008, 0, 0, 9'h000, 0);
        send(MTD_OP_DFP_ST, 0, 8'h00, 1, 8'h3c, 64'h2010, 1, 0, 9'h000, 0);
        send(MTD_OP_DFP_LD, 0, 8'h00, 0, 8'h01, 64'h2004, 0, 0, `MTD_TT_ILLEGAL, 0);
        send(MTD_OP_DFP_ST, 0, 8'h00, 1, 8'h00, 64'h2006, 0, 0, `MTD_TT_MEM_MISALIGN, 0);
    endtask : t_double

    task automatic t_selector();
        send(MTD_OP_DFP_LD, 1, 8'h80, 1, 8'h00, 64'h0008, 0, 0, 9'h000, 0);
        send(MTD_OP_DFP_LD, 1, 8'h00, 1, 8'h00, 64'h0004, 0, 0, `MTD_TT_PRIV_ACTION, 0);
        send(MTD_OP_DFP_ST, 1, 8'h7f, 1, 8'h00, 64'h0008, 1, 0, `MTD_TT_PRIV_ACTION, 0);
        send(MTD_OP_DFP_LD, 1, 8'h2f, 1, 8'h00, 64'h0004, 1, 0, `MTD_TT_DLD_MISALIGN, 0);
    endtask : t_selector

    task automatic t_twin();
        send(MTD_OP_TWIN_LD, 0, 8'h00, 1, 8'h00, 64'h0000, 0, 0, `MTD_TT_TWIN_LD, 0);
        send(MTD_OP_TWIN_ST, 1, 8'h80, 1, 8'h00, 64'h0008, 0, 0, `MTD_TT_TWIN_ST, 0);
    endtask : t_twin

    task automatic t_prefetch();
        for (int f = 0; f < 32; f++) begin
            send(MTD_OP_PREFETCH, 0, 8'h00, 1, 8'h00, 64'h1234_5678_9abc_def7, 1, f[8:0], 9'h000, !PF_DEF[f]);
            if (PF_DEF[f]) check("pf_mode", rsp.pf_mode, MTD_PF_COMMON);
            check("pf_addr", rsp.pf_addr, 64'h1234_5678_9abc_dec0);
        end
        send(MTD_OP_PREFETCH, 1, 8'h05, 1, 8'h00, 64'h0040, 0, 0, 9'h000, 1);
        send(MTD_OP_PREFETCH, 1, 8'h40, 1, 8'h00, 64'h0040, 1, 0, 9'h000, 1);
    endtask : t_prefetch

    task automatic t_misc();
        send(MTD_OP_ISYNC, 0, 8'h00, 1, 8'h00, 64'h0000, 0, 0, 9'h000, 0);
        send(MTD_OP_WIN_CLEAN, 0, 8'h00, 1, 8'h00, 64'h0000, 1, 0, `MTD_TT_WIN_SCRUB, 0);
        check("hw_clean", rsp.hw_clean, 1'b0);
        send(MTD_OP_IMPL_TRAP, 0, 8'h00, 1, 8'h00, 64'h0000, 1, 9'h065, `MTD_TT_PRIVATE_DFLT, 0);
        send(MTD_OP_IMPL_TRAP, 0, 8'h00, 1, 8'h00, 64'h0000, 1, 9'h1a0, 9'h1a0, 0);
    endtask : t_misc

    task automatic t_depth();
        repeat (TL_LIM + 1) u_pipe.ret();
        exp_tl = 0;
        check("level", level, exp_tl);
        repeat (TL_LIM + 1) send(MTD_OP_WIN_CLEAN, 0, 8'h00, 1, 8'h00, 64'h0000, 1, 0, `MTD_TT_WIN_SCRUB, 0);
        check("level", level, exp_tl);
        check("at_max", at_max, 1'b1);
        u_pipe.ret();
        check("level", level, TL_LIM - 1);
    endtask : t_depth

    task automatic t_count();
        logic [62:0] c0;
        c0 = count;
        repeat (5) @(negedge clk);
        check("count", count, c0 + 63'h5);
        check("count_hi", count[62:53], 10'h000);
    endtask : t_count

    // Main sequence after three cycles of reset
    initial begin
        repeat (3) @(negedge clk);
        rst_n = 1'b1;
        t_reset();
        t_double();
        t_selector();
        t_twin();
        t_prefetch();
        t_misc();
        t_depth();
        t_count();
        end_sim();
    end
endmodule : memory_op_trap_decision_tb
